/* File: rtl/idpb_defines.vh */
`ifndef IDPB_DEFINES_VH
`define IDPB_DEFINES_VH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define IDPB_REG_DEF_CYL      8'h00
`define IDPB_REG_DEF_HEADS    8'h04
`define IDPB_REG_DEF_SPT      8'h08
`define IDPB_REG_CUR_CYL      8'h0C
`define IDPB_REG_CUR_HEADS    8'h10
`define IDPB_REG_CUR_SPT      8'h14
`define IDPB_REG_TOTAL_SECT   8'h18
`define IDPB_REG_LBA48_LO     8'h1C
`define IDPB_REG_LBA48_HI     8'h20
`define IDPB_REG_MODE         8'h24
`define IDPB_REG_USER_ID0     8'h28
`define IDPB_REG_USER_ID1     8'h2C
`define IDPB_REG_USER_ID2     8'h30
`define IDPB_REG_STATUS       8'h34

// ---------------------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------------------
`define IDPB_MODE_MULT_MSB    7
`define IDPB_MODE_DMA_LSB     8
`define IDPB_DMA_SEL_NONE     2'h0
`define IDPB_RST_GEOM         16'h0000
`define IDPB_RST_MULT         8'h00
`define IDPB_RST_USER_ID      80'h30303030303030303030
`define IDPB_RESP_OKAY        2'h0
`define IDPB_RESP_SLVERR      2'h2

// ---------------------------------------------------------------------------
// Block layout and fixed word values
// ---------------------------------------------------------------------------
`define IDPB_LAST_WORD        8'hFF
`define IDPB_LAST_SUM_WORD    8'hFE
`define IDPB_SIGNATURE        8'hA5
`define IDPB_W0_GENCFG        16'h044A
`define IDPB_W47_MAXMULT      16'h8001
`define IDPB_W49_CAPS         16'h0B00
`define IDPB_W51_PIO          16'h0200
`define IDPB_W53_VALID        16'h0007
`define IDPB_W59_VALIDFLAG    8'h01
`define IDPB_W63_SUPPORTED    3'h7
`define IDPB_W64_ADVPIO       16'h0003
`define IDPB_W65_CYCLE        16'h0078
`define IDPB_W80_MAJOR        16'h00FE
`define IDPB_W81_MINOR        16'h0021
`define IDPB_W82_FEAT         16'h706B
`define IDPB_W83_FEAT         16'h7408
`define IDPB_W84_FEAT         16'h4000
`define IDPB_W88_UDMA         16'h007F
`define IDPB_W91_APM          16'h0000
`define IDPB_W217_ROTATION    16'h0001

`endif

/* File: rtl/idpb_identify.v */
`timescale 1ns/100ps
`include "idpb_defines.vh"

module idpb_identify #(
   parameter [79:0]  UNIQUE_ID = 80'h31323334353637383930, // Arbitrary value.
   parameter [63:0]  FW_REV    = 64'h2020202020202020,
   parameter [319:0] MODEL     = {40{8'h20}}
) (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address and data
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   output reg  [1:0]  s_axi_bresp,
   // AXI4-Lite read
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   input  wire [7:0]  s_axi_araddr,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   // Identify data stream toward the PIO data path
   input  wire        xfer_start,
   input  wire        xfer_take,
   output reg         xfer_ready,
   output reg  [15:0] xfer_data,
   output reg         xfer_done,
   output reg         xfer_busy
);

   // ------------------------------------------------------------------------
   // State encoding
   // ------------------------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_CALC = 2'd1;
   localparam [1:0] ST_SEND = 2'd2;

   reg  [1:0]  state;
   reg  [7:0]  idx;
   reg  [7:0]  sum;
   reg  [7:0]  checksum;

   reg  [15:0] def_cyl;
   reg  [15:0] def_heads;
   reg  [15:0] def_spt;
   reg  [15:0] cur_cyl;
   reg  [15:0] cur_heads;
   reg  [15:0] cur_spt;
   reg  [31:0] total_sect;
   reg  [31:0] lba48_lo;
   reg  [15:0] lba48_hi;
   reg  [7:0]  mult_count;
   reg  [1:0]  dma_sel;
   reg  [79:0] user_id;
   reg  [31:0] cur_cap;

   reg         aw_full;
   reg         w_full;
   reg  [7:0]  aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;

   wire [47:0] cap_product = cur_cyl * cur_heads * cur_spt;
   wire [15:0] calc_word;
   wire [15:0] mode_merged;

   // ------------------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------------------
   function [15:0] pick_word;
      input [319:0] s;
      input [4:0]   k;
      reg   [319:0] t;
      begin
         t = s << {k, 4'h0};
         pick_word = t[319:304];
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0]  strb;
      integer      b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               merge[b*8 +: 8] = data[b*8 +: 8];
            end
         end
      end
   endfunction

   // Narrow registers take only the two low byte lanes; the upper lanes are dropped.
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0]  strb;
      reg   [31:0] full;
      begin
         full    = merge({16'h0000, old}, data, strb);
         merge16 = full[15:0];
      end
   endfunction

   // Strings are sent first character in the high byte of each word.
   function [15:0] word_value;
      input [7:0] w;
      begin
         word_value = 16'h0000;
         if (w >= 8'd10 && w <= 8'd14) begin
            word_value = pick_word({user_id, 240'h0}, w[4:0] - 5'd10);
         end else if (w >= 8'd15 && w <= 8'd19) begin
            word_value = pick_word({UNIQUE_ID, 240'h0}, w[4:0] - 5'd15);
         end else if (w >= 8'd23 && w <= 8'd26) begin
            word_value = pick_word({FW_REV, 256'h0}, w[4:0] - 5'd23);
         end else if (w >= 8'd27 && w <= 8'd46) begin
            word_value = pick_word(MODEL, w[4:0] - 5'd27);
         end else if (w >= 8'd65 && w <= 8'd68) begin
            word_value = `IDPB_W65_CYCLE;
         end else begin
            case (w)
               8'd0:    word_value = `IDPB_W0_GENCFG;
               8'd1:    word_value = def_cyl;
               8'd3:    word_value = def_heads;
               8'd6:    word_value = def_spt;
               8'd7:    word_value = total_sect[31:16];
               8'd8:    word_value = total_sect[15:0];
               8'd47:   word_value = `IDPB_W47_MAXMULT;
               8'd49:   word_value = `IDPB_W49_CAPS;
               8'd51:   word_value = `IDPB_W51_PIO;
               8'd53:   word_value = `IDPB_W53_VALID;
               8'd54:   word_value = cur_cyl;
               8'd55:   word_value = cur_heads;
               8'd56:   word_value = cur_spt;
               8'd57:   word_value = cur_cap[15:0];
               8'd58:   word_value = cur_cap[31:16];
               8'd59:   word_value = {`IDPB_W59_VALIDFLAG, mult_count};
               8'd60:   word_value = total_sect[15:0];
               8'd61:   word_value = total_sect[31:16];
               8'd63:   word_value = {5'h00, dma_sel == 2'd3, dma_sel == 2'd2,
                                      dma_sel == 2'd1, 5'h00,
                                      `IDPB_W63_SUPPORTED};
               8'd64:   word_value = `IDPB_W64_ADVPIO;
               8'd80:   word_value = `IDPB_W80_MAJOR;
               8'd81:   word_value = `IDPB_W81_MINOR;
               8'd82:   word_value = `IDPB_W82_FEAT;
               8'd83:   word_value = `IDPB_W83_FEAT;
               8'd84:   word_value = `IDPB_W84_FEAT;
               8'd88:   word_value = `IDPB_W88_UDMA;
               8'd91:   word_value = `IDPB_W91_APM;
               8'd100:  word_value = lba48_lo[15:0];
               8'd101:  word_value = lba48_lo[31:16];
               8'd102:  word_value = lba48_hi;
               8'd217:  word_value = `IDPB_W217_ROTATION;
               8'd255:  word_value = {checksum, `IDPB_SIGNATURE};
               default: word_value = 16'h0000;
            endcase
         end
      end
   endfunction

   assign calc_word   = word_value(idx);
   assign mode_merged = merge16({6'h00, dma_sel, mult_count}, w_data, w_strb);

   // ------------------------------------------------------------------------
   // Block sequencer
   // ------------------------------------------------------------------------
   // The checksum is formed in a pre-pass over words 0 to 254, so the stream
   // starts 256 cycles after the start pulse. Configuration writes are refused
   // while busy, which keeps the pre-pass and the stream consistent.
   always @(posedge aclk) begin
      if (!aresetn) begin
         state      <= ST_IDLE;
         idx        <= 8'h00;
         sum        <= 8'h00;
         checksum   <= 8'h00;
         xfer_ready <= 1'b0;
         xfer_data  <= 16'h0000;
         xfer_done  <= 1'b0;
         xfer_busy  <= 1'b0;
         cur_cap    <= 32'h0000_0000;
      end else begin
         cur_cap   <= cap_product[31:0];
         xfer_done <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (xfer_start) begin
                  state     <= ST_CALC;
                  idx       <= 8'h00;
                  sum       <= 8'h00;
                  xfer_busy <= 1'b1;
               end
            end
            ST_CALC: begin
               if (idx == `IDPB_LAST_SUM_WORD) begin
                  checksum  <= 8'h00 - (sum + calc_word[15:8] + calc_word[7:0]
                                        + `IDPB_SIGNATURE);
                  idx       <= 8'h00;
                  state     <= ST_SEND;
               end else begin
                  sum <= sum + calc_word[15:8] + calc_word[7:0];
                  idx <= idx + 8'h01;
               end
            end
            ST_SEND: begin
               // Words leave one at a time as for a single-sector read.
               if (!xfer_ready) begin
                  xfer_ready <= 1'b1;
                  xfer_data  <= calc_word;
               end else if (xfer_take) begin
                  if (idx == `IDPB_LAST_WORD) begin
                     xfer_ready <= 1'b0;
                     xfer_done  <= 1'b1;
                     xfer_busy  <= 1'b0;
                     xfer_data  <= 16'h0000;
                     state      <= ST_IDLE;
                  end else begin
                     idx       <= idx + 8'h01;
                     xfer_data <= word_value(idx + 8'h01);
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `IDPB_RESP_OKAY;
         aw_full       <= 1'b0;
         w_full        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         def_cyl       <= `IDPB_RST_GEOM;
         def_heads     <= `IDPB_RST_GEOM;
         def_spt       <= `IDPB_RST_GEOM;
         cur_cyl       <= `IDPB_RST_GEOM;
         cur_heads     <= `IDPB_RST_GEOM;
         cur_spt       <= `IDPB_RST_GEOM;
         total_sect    <= 32'h0000_0000;
         lba48_lo      <= 32'h0000_0000;
         lba48_hi      <= 16'h0000;
         mult_count    <= `IDPB_RST_MULT;
         dma_sel       <= `IDPB_DMA_SEL_NONE;
         user_id       <= `IDPB_RST_USER_ID;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (aw_full && w_full && !s_axi_bvalid) begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `IDPB_RESP_OKAY;
            if (aw_addr[1:0] != 2'b00 || aw_addr > `IDPB_REG_STATUS || xfer_busy) begin
               s_axi_bresp <= `IDPB_RESP_SLVERR;
            end else begin
               case (aw_addr)
                  `IDPB_REG_DEF_CYL:    def_cyl    <= merge16(def_cyl, w_data, w_strb);
                  `IDPB_REG_DEF_HEADS:  def_heads  <= merge16(def_heads, w_data, w_strb);
                  `IDPB_REG_DEF_SPT:    def_spt    <= merge16(def_spt, w_data, w_strb);
                  `IDPB_REG_CUR_CYL:    cur_cyl    <= merge16(cur_cyl, w_data, w_strb);
                  `IDPB_REG_CUR_HEADS:  cur_heads  <= merge16(cur_heads, w_data, w_strb);
                  `IDPB_REG_CUR_SPT:    cur_spt    <= merge16(cur_spt, w_data, w_strb);
                  `IDPB_REG_TOTAL_SECT: total_sect <= merge(total_sect, w_data, w_strb);
                  `IDPB_REG_LBA48_LO:   lba48_lo   <= merge(lba48_lo, w_data, w_strb);
                  `IDPB_REG_LBA48_HI:   lba48_hi   <= merge16(lba48_hi, w_data, w_strb);
                  `IDPB_REG_MODE: begin
                     // A two-bit select can name only one DMA mode at once.
                     {dma_sel, mult_count} <= mode_merged[9:0];
                  end
                  `IDPB_REG_USER_ID0:   user_id[79:48] <= merge(user_id[79:48], w_data, w_strb);
                  `IDPB_REG_USER_ID1:   user_id[47:16] <= merge(user_id[47:16], w_data, w_strb);
                  `IDPB_REG_USER_ID2:   user_id[15:0]  <= merge16(user_id[15:0], w_data, w_strb);
                  default: begin
                     s_axi_bresp <= `IDPB_RESP_OKAY;
                  end
               endcase
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `IDPB_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `IDPB_RESP_OKAY;
            case (s_axi_araddr)
               `IDPB_REG_DEF_CYL:    s_axi_rdata <= {16'h0, def_cyl};
               `IDPB_REG_DEF_HEADS:  s_axi_rdata <= {16'h0, def_heads};
               `IDPB_REG_DEF_SPT:    s_axi_rdata <= {16'h0, def_spt};
               `IDPB_REG_CUR_CYL:    s_axi_rdata <= {16'h0, cur_cyl};
               `IDPB_REG_CUR_HEADS:  s_axi_rdata <= {16'h0, cur_heads};
               `IDPB_REG_CUR_SPT:    s_axi_rdata <= {16'h0, cur_spt};
               `IDPB_REG_TOTAL_SECT: s_axi_rdata <= total_sect;
               `IDPB_REG_LBA48_LO:   s_axi_rdata <= lba48_lo;
               `IDPB_REG_LBA48_HI:   s_axi_rdata <= {16'h0, lba48_hi};
               `IDPB_REG_MODE:       s_axi_rdata <= {22'h0, dma_sel, mult_count};
               `IDPB_REG_USER_ID0:   s_axi_rdata <= user_id[79:48];
               `IDPB_REG_USER_ID1:   s_axi_rdata <= user_id[47:16];
               `IDPB_REG_USER_ID2:   s_axi_rdata <= {16'h0, user_id[15:0]};
               `IDPB_REG_STATUS:     s_axi_rdata <= {8'h00, idx, checksum, 5'h00,
                                                     state == ST_SEND, xfer_ready,
                                                     xfer_busy};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `IDPB_RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // idpb_identify

/* File: sim/idpb_asserts.sv */
`timescale 1ns/100ps
module idpb_asserts (
   input logic        aclk,
   input logic        aresetn,
   input logic        xfer_take,
   input logic        xfer_ready,
   input logic [15:0] xfer_data,
   input logic        xfer_done,
   input logic        xfer_busy
);
   // ------------------------------------------------------------
   // Word index and byte sum of the frame in flight
   // ------------------------------------------------------------
   logic [7:0] idx;
   logic [7:0] sum;
   wire        tk = xfer_take && xfer_ready;
   always @(posedge aclk) begin
      if (!aresetn || xfer_done) begin
         idx <= 8'h00;
         sum <= 8'h00;
      end else if (tk) begin
         idx <= idx + 8'h01;
         sum <= sum + xfer_data[15:8] + xfer_data[7:0];
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence last_take;
      tk && idx == 8'hFF;
   endsequence
   sequence frame_end;
      xfer_done && !xfer_ready && !xfer_busy;
   endsequence
   sig_byte_a: assert property (
      last_take |-> xfer_data[7:0] == 8'hA5) else $error("Bad signature byte.");
   sum_zero_a: assert property (
      xfer_done |-> sum == 8'h00) else $error("Block bytes do not sum to zero.");
   apm_zero_a: assert property (
      xfer_ready && idx == 8'h5B |-> xfer_data == 16'h0000) else $error("Word 91 not zero.");
   rot_rate_a: assert property (
      xfer_ready && idx == 8'hD9 |-> xfer_data == 16'h0001) else $error("Word 217 wrong.");
   max_mult_a: assert property (
      xfer_ready && idx == 8'h2F |-> xfer_data[7:0] == 8'h01) else $error("Word 47 wrong.");
   caps_bits_a: assert property (
      xfer_ready && idx == 8'h31 |-> !xfer_data[13] && xfer_data[11] && xfer_data[9]
      && xfer_data[8]) else $error("Capability bits wrong.");
   dma_mode_a: assert property (
      xfer_ready && idx == 8'h3F |-> $onehot0(xfer_data[10:8])
      && (!xfer_data[2] || xfer_data[1:0] == 2'h3)) else $error("DMA mode word wrong.");
   valid_word_a: assert property (
      xfer_ready && idx == 8'h35 |-> xfer_data[2:0] == 3'h7) else $error("Word 53 wrong.");
   frame_end_a: assert property (
      last_take |=> frame_end) else $error("Frame did not close after last word.");
   ready_lat_a: assert property (
      $rose(xfer_busy) |-> ##256 $rose(xfer_ready)) else $error("First word late or early.");
endmodule // idpb_asserts
bind idpb_identify idpb_asserts u_asserts (
   .aclk(aclk), .aresetn(aresetn), .xfer_take(xfer_take), .xfer_ready(xfer_ready),
   .xfer_data(xfer_data), .xfer_done(xfer_done), .xfer_busy(xfer_busy));

/* File: sim/idpb_host_model.sv */
`timescale 1ns/100ps
module idpb_host_model (
   input  logic        aclk,
   input  logic        aresetn,
   input  logic        go,
   input  logic        slow,
   input  logic        xfer_ready,
   input  logic [15:0] xfer_data,
   output logic        xfer_start,
   output logic        xfer_take
);
   // ------------------------------------------------------------
   // Host side of the data-in transfer; slow mode skips every fourth cycle
   // ------------------------------------------------------------
   logic [15:0] words [0:255];
   logic [8:0]  count;
   logic [1:0]  pace;
   always @(posedge aclk) begin
      if (!aresetn) begin
         xfer_start <= 1'b0;
         xfer_take  <= 1'b0;
         count      <= 9'h000;
         pace       <= 2'h0;
      end else begin
         xfer_start <= go;
         pace       <= pace + 2'h1;
         xfer_take  <= !slow || pace != 2'h3;
         if (go) begin
            count <= 9'h000;
         end else if (xfer_ready && xfer_take) begin
            words[count[7:0]] <= xfer_data;
            count <= count + 9'h001;
         end
      end
   end
endmodule // idpb_host_model

/* File: sim/identify_parameter_block_tb_top.sv */
`timescale 1ns/100ps
`include "idpb_defines.vh"
module identify_parameter_block_tb_top;
   localparam logic [15:0] DCYL = 16'h1E2D, DHD = 16'h0010, DSPT = 16'h003F;
   localparam logic [15:0] CCYL = 16'h3FFF, CHD = 16'h000F, CSPT = 16'h0020, L48H = 16'h0005;
   localparam logic [31:0] TOT = 32'h01DF_FC10, L48 = 32'h01DF_FC0F;
   localparam logic [31:0] CAP = 32'(CCYL) * 32'(CHD) * 32'(CSPT);
   localparam logic [79:0] UID = 80'h4142_4344_4546_4748_494A;
   logic        aclk, aresetn, awv, wv, br, arv, rr, go, slow, start, take;
   logic        awr, wrdy, bv, arr, rv, xready, xdone, xbusy;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rdata;
   logic [1:0]  bresp, rresp;
   logic [3:0]  ws;
   logic [15:0] xdata;
   int          mismatches, compares;
   idpb_identify #(.UNIQUE_ID(UID)) uut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .xfer_start(start),
      .xfer_take(take), .xfer_ready(xready), .xfer_data(xdata), .xfer_done(xdone),
      .xfer_busy(xbusy));
   idpb_host_model h (
      .aclk(aclk), .aresetn(aresetn), .go(go), .slow(slow), .xfer_ready(xready),
      .xfer_data(xdata), .xfer_start(start), .xfer_take(take));
   always #5 aclk = ~aclk;
   // ------------------------------------------------------------
   // Bus tasks, expected block contents and checks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awv <= 1'b1;
      wv  <= 1'b1;
      awa <= a;
      wd  <= d;
      br  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end while (!bv);
      br <= 1'b0;
      chk(32'(bresp), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      arv <= 1'b1;
      rr  <= 1'b1;
      ara <= a;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      rr <= 1'b0;
      chk(rdata, ed);
      chk(32'(rresp), 32'(er));
   endtask
   function automatic logic [16:0] ew(input int i, input logic [1:0] s, input logic [7:0] m);
      case (i) inside
         0: return {1'b1, 16'h044A};
         1: return {1'b1, DCYL};
         3: return {1'b1, DHD};
         6: return {1'b1, DSPT};
         7, 61: return {1'b1, TOT[31:16]};
         8, 60: return {1'b1, TOT[15:0]};
         [10:14]: return {1'b1, 16'h3030};
         [15:19]: return {1'b1, UID[79-16*(i-15) -: 16]};
         47: return {1'b1, 16'h8001};
         49: return {1'b1, 16'h0B00};
         51: return {1'b1, 16'h0200};
         53: return {1'b1, 16'h0007};
         54: return {1'b1, CCYL};
         55: return {1'b1, CHD};
         56: return {1'b1, CSPT};
         57: return {1'b1, CAP[15:0]};
         58: return {1'b1, CAP[31:16]};
         59: return {1'b1, 8'h01, m};
         63: return {1'b1, 5'h00, s == 2'h3, s == 2'h2, s == 2'h1, 8'h07};
         64: return {1'b1, 16'h0003};
         100: return {1'b1, L48[15:0]};
         101: return {1'b1, L48[31:16]};
         102: return {1'b1, L48H};
         217: return {1'b1, 16'h0001};
         2, 4, 5, 20, 48, 50, 52, 62, [69:79], 91, 92, [94:99], [103:127], [129:216],
         [218:254]: return {1'b1, 16'h0000};
         default: return 17'h00000;
      endcase
   endfunction
   task automatic frame(input logic [1:0] s, input logic [7:0] m);
      logic [16:0] e;
      logic [7:0]  sum;
      @(posedge aclk);
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      wr(`IDPB_REG_DEF_CYL, 32'h0000_0BAD, `IDPB_RESP_SLVERR);
      while (!xdone) @(posedge aclk);
      sum = 8'h00;
      for (int i = 0; i < 256; i++) begin
         e = ew(i, s, m);
         sum = sum + h.words[i][15:8] + h.words[i][7:0];
         if (e[16]) chk(32'(h.words[i]), 32'(e[15:0]));
      end
      chk(32'(h.words[255][7:0]), 32'h0000_00A5);
      chk(32'(sum), 32'h0000_0000);
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      conclude();
   end
   initial begin
      {aclk, aresetn, awv, wv, br, arv, rr, go, slow, awa, ara, wd} = '0;
      ws = 4'hF;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`IDPB_REG_MODE, 32'h0, `IDPB_RESP_OKAY);
      rd(`IDPB_REG_USER_ID0, 32'h3030_3030, `IDPB_RESP_OKAY);
      ws <= 4'h2;
      wr(`IDPB_REG_DEF_CYL, 32'h1234_AB56, `IDPB_RESP_OKAY);
      rd(`IDPB_REG_DEF_CYL, 32'h0000_AB00, `IDPB_RESP_OKAY);
      ws <= 4'hF;
      wr(`IDPB_REG_DEF_CYL, 32'(DCYL), `IDPB_RESP_OKAY);
      wr(`IDPB_REG_DEF_HEADS, 32'(DHD), `IDPB_RESP_OKAY);
      wr(`IDPB_REG_DEF_SPT, 32'(DSPT), `IDPB_RESP_OKAY);
      wr(`IDPB_REG_CUR_CYL, 32'(CCYL), `IDPB_RESP_OKAY);
      wr(`IDPB_REG_CUR_HEADS, 32'(CHD), `IDPB_RESP_OKAY);
      wr(`IDPB_REG_CUR_SPT, 32'(CSPT), `IDPB_RESP_OKAY);
      wr(`IDPB_REG_TOTAL_SECT, TOT, `IDPB_RESP_OKAY);
      wr(`IDPB_REG_LBA48_LO, L48, `IDPB_RESP_OKAY);
      wr(`IDPB_REG_LBA48_HI, {16'hFFFF, L48H}, `IDPB_RESP_OKAY);
      wr(8'h02, 32'h0000_0001, `IDPB_RESP_SLVERR);
      wr(8'h38, 32'h0000_0001, `IDPB_RESP_SLVERR);
      rd(`IDPB_REG_LBA48_HI, 32'(L48H), `IDPB_RESP_OKAY);
      rd(8'h38, 32'h0, `IDPB_RESP_SLVERR);
      for (int s = 0; s < 4; s++) begin
         slow <= s[0];
         wr(`IDPB_REG_MODE, {22'h0, s[1:0], s[1:0], 6'h00}, `IDPB_RESP_OKAY);
         frame(s[1:0], {s[1:0], 6'h00});
      end
      conclude();
   end
endmodule // identify_parameter_block_tb_top
